// file: pin_board_model.sv
// Board side of the eight standby pins: resolves each pin level.
// Assumes the bench supplies extLevel/extEn for external drivers.
`timescale 1ns/1ps
module pin_board_model (
    input wire logic clock,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOutEn,
    input wire logic [7:0] pinPullUpEn,
    input wire logic [7:0] extLevel,
    input wire logic [7:0] extEn,
    output logic [7:0] pinLevel
);
    // A floating pin wanders each cycle so it never reads as a steady value
    logic [7:0] wander = 8'h55;
    always @(posedge clock) begin
        wander <= ~wander;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pinOutEn[i])
                pinLevel[i] = pinOut[i];
            else if (extEn[i])
                pinLevel[i] = extLevel[i];
            else if (pinPullUpEn[i])
                pinLevel[i] = 1'b1;
            else
                pinLevel[i] = wander[i];
        end
    end
endmodule

// file: standby_gpio_event_port.v
// Standby GPIO event port: eight pins, per-pin configuration behind an
// index register, data-out and data-in runtime registers, event status.
// Assumes an APB master, pins sampled synchronously, pad logic outside.
`timescale 1ns/1ps
`include "standby_gpio_regs.vh"

module standby_gpio_event_port (
    input wire clock,
    input wire rst,
    input wire standbyPowerUpRst,
    input wire controllerActive,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [7:0] pinIn,
    output reg [7:0] pinOut,
    output reg [7:0] pinOutEn,
    output reg [7:0] pinPullUpEn,
    output reg [7:0] eventPending
);

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    reg [7:0] pinConfig [0:7];
    reg [7:0] pinIndex;
    reg [7:0] outValue;
    reg [7:0] eventStatus;
    reg [7:0] pinSample;
    reg [7:0] stableLevel;
    reg [7:0] prevDetect;
    reg [7:0] prevDetectValid;
    reg [3:0] bounceCount [0:7];
    reg [15:0] tickCount;
    reg msTick;

    wire [2:0] selPin = pinIndex[2:0];
    wire portZero = ~pinIndex[4];
    wire setupPhase = psel & ~penable;
    wire accessDone = psel & penable & pready;
    wire writeDone = accessDone & pwrite & pstrb[0];
    wire [7:0] wByte = pwdata[7:0];

    // ---------------------------------------------------------------
    // Address decoding
    // ---------------------------------------------------------------
    function mapped;
        input [11:0] a;
        begin
            case (a)
                `ADDR_PIN_INDEX: mapped = 1'b1;
                `ADDR_PIN_CONFIG: mapped = 1'b1;
                `ADDR_OUT_VALUE: mapped = 1'b1;
                `ADDR_IN_LEVEL: mapped = 1'b1;
                `ADDR_EVENT_STATUS: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    // Runtime registers vanish while the controller is inactive.
    function runtimeAddr;
        input [11:0] a;
        begin
            case (a)
                `ADDR_OUT_VALUE: runtimeAddr = 1'b1;
                `ADDR_IN_LEVEL: runtimeAddr = 1'b1;
                default: runtimeAddr = 1'b0;
            endcase
        end
    endfunction

    wire accessOk = mapped(paddr) & ~(runtimeAddr(paddr) & ~controllerActive);

    // ---------------------------------------------------------------
    // APB slave: one wait-free access phase, answer registered
    // ---------------------------------------------------------------
    reg [7:0] readByte;
    always @* begin
        readByte = 8'h00;
        case (paddr)
            `ADDR_PIN_INDEX: readByte = pinIndex;
            // Reserved port 1 reads as zero rather than aliasing port 0.
            `ADDR_PIN_CONFIG: readByte = portZero ? pinConfig[selPin] : 8'h00;
            `ADDR_OUT_VALUE: readByte = outValue;
            `ADDR_IN_LEVEL: readByte = pinSample;
            `ADDR_EVENT_STATUS: readByte = eventStatus;
            default: readByte = 8'h00;
        endcase
    end

    always @(posedge clock) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPhase;
            if (setupPhase) begin
                prdata <= (accessOk & ~pwrite) ? {24'h000000, readByte} : 32'h00000000;
                pslverr <= ~accessOk;
            end else if (accessDone) begin
                pslverr <= 1'b0;
                prdata <= 32'h00000000;
            end
        end
    end

    // ---------------------------------------------------------------
    // Pin select and data out
    // ---------------------------------------------------------------
    wire wrIndex = writeDone & (paddr == `ADDR_PIN_INDEX);
    wire wrConfig = writeDone & (paddr == `ADDR_PIN_CONFIG) & portZero;
    wire wrOut = writeDone & (paddr == `ADDR_OUT_VALUE) & controllerActive;
    wire wrStatus = writeDone & (paddr == `ADDR_EVENT_STATUS);

    always @(posedge clock) begin
        if (rst) begin
            pinIndex <= `SEL_RESET;
        end else if (wrIndex) begin
            pinIndex <= wByte & `SEL_WRITE_MASK;
        end
    end

    reg [7:0] lockMask;
    integer k;
    always @* begin
        lockMask = 8'h00;
        for (k = 0; k < 8; k = k + 1) begin
            lockMask[k] = pinConfig[k][`CFG_LOCK];
        end
    end

    // A locked pin keeps its output value across software reset.
    always @(posedge clock) begin
        if (standbyPowerUpRst) begin
            outValue <= `OUT_RESET;
        end else if (rst) begin
            outValue <= (outValue & lockMask) | (`OUT_RESET & ~lockMask);
        end else if (wrOut) begin
            outValue <= ((wByte & `BIDIR_MASK) & ~lockMask) | (outValue & lockMask);
        end
    end

    // ---------------------------------------------------------------
    // Per-pin configuration, debounce and event detection
    // ---------------------------------------------------------------
    wire [7:0] bidirPins;
    wire [7:0] cfgHit;
    wire [7:0] lockedPin;
    wire [7:0] rawLevel;
    wire [7:0] bounced;
    wire [7:0] bounceDone;
    wire [7:0] debounceOn;
    wire [7:0] detectIn;
    wire [7:0] activeLevel;
    wire [7:0] edgeSeen;
    wire [7:0] eventHit;
    wire [7:0] clearHit;
    wire [7:0] outEnBits;
    wire [7:0] pushPullBits;
    wire [7:0] pullUpBits;
    wire [7:0] cfgMask [0:7];
    wire [7:0] keepMask [0:7];
    wire [7:0] merged [0:7];
    wire [7:0] nextCfg [0:7];
    wire [7:0] softCfg [0:7];

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : pinSlice
            assign bidirPins[g] = (g < 6);
            assign cfgMask[g] = (g < 6) ? `CFG_WRITE_MASK : `CFG_INPUT_ONLY_MASK;
            assign cfgHit[g] = wrConfig & (selPin == g);
            assign lockedPin[g] = pinConfig[g][`CFG_LOCK];
            assign keepMask[g] = lockedPin[g] ? 8'h0f : 8'h00;
            assign merged[g] = (wByte & cfgMask[g] & ~keepMask[g]) | (pinConfig[g] & keepMask[g]);
            // Lock is set-only: once set it stays until standby power-up.
            assign nextCfg[g] = {merged[g][7:4], merged[g][3] | lockedPin[g], merged[g][2:0]};
            assign softCfg[g] = (`CFG_RESET & cfgMask[g] & ~keepMask[g]) | (pinConfig[g] & keepMask[g]);
            assign rawLevel[g] = pinSample[g];
            assign bounced[g] = (rawLevel[g] != stableLevel[g]);
            assign bounceDone[g] = (bounceCount[g] == `DEBOUNCE_MS - 1);
            assign debounceOn[g] = pinConfig[g][`CFG_DEBOUNCE];
            assign detectIn[g] = debounceOn[g] ? stableLevel[g] : rawLevel[g];
            assign activeLevel[g] = ~(detectIn[g] ^ pinConfig[g][`CFG_POLARITY]);
            assign edgeSeen[g] = prevDetectValid[g] & (prevDetect[g] != detectIn[g]) & activeLevel[g];
            assign eventHit[g] = pinConfig[g][`CFG_LEVEL_TYPE] ? activeLevel[g] : edgeSeen[g];
            assign clearHit[g] = wrStatus & wByte[g];
            assign outEnBits[g] = pinConfig[g][`CFG_OUT_EN];
            assign pushPullBits[g] = pinConfig[g][`CFG_PUSH_PULL];
            assign pullUpBits[g] = pinConfig[g][`CFG_PULL_UP];
        end
    endgenerate

    // ---------------------------------------------------------------
    // Configuration storage
    // ---------------------------------------------------------------
    integer p;
    always @(posedge clock) begin
        for (p = 0; p < 8; p = p + 1) begin
            if (standbyPowerUpRst) begin
                pinConfig[p] <= `CFG_RESET & cfgMask[p];
            end else if (rst) begin
                // Software reset leaves a locked pin's bits 0-3 untouched.
                pinConfig[p] <= softCfg[p];
            end else if (cfgHit[p]) begin
                pinConfig[p] <= nextCfg[p];
            end
        end
    end

    // ---------------------------------------------------------------
    // Debounce timebase
    // ---------------------------------------------------------------
    // One shared millisecond tick keeps the per-pin counters at four bits.
    // Trade-off: the quiet period is 14 to 15 ms, as the tick phase is free.
    always @(posedge clock) begin
        if (rst) begin
            tickCount <= 16'h0000;
            msTick <= 1'b0;
        end else if (tickCount == `DEBOUNCE_TICK_CYCLES - 1) begin
            tickCount <= 16'h0000;
            msTick <= 1'b1;
        end else begin
            tickCount <= tickCount + 16'h0001;
            msTick <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Per-pin debounce
    // ---------------------------------------------------------------
    // Counter restarts whenever the raw input matches the held level again.
    integer q;
    always @(posedge clock) begin
        for (q = 0; q < 8; q = q + 1) begin
            if (rst) begin
                bounceCount[q] <= 4'h0;
                stableLevel[q] <= 1'b1;
            end else if (!bounced[q]) begin
                bounceCount[q] <= 4'h0;
            end else if (msTick & bounceDone[q]) begin
                bounceCount[q] <= 4'h0;
                stableLevel[q] <= rawLevel[q];
            end else if (msTick) begin
                bounceCount[q] <= bounceCount[q] + 4'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Event detection and status
    // ---------------------------------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            eventStatus <= 8'h00;
            prevDetect <= 8'h00;
            prevDetectValid <= 8'h00;
        end else begin
            prevDetect <= detectIn;
            prevDetectValid <= 8'hff;
            // Set wins over a clear in the same cycle.
            eventStatus <= eventHit | (eventStatus & ~clearHit);
        end
    end

    // ---------------------------------------------------------------
    // Pin drivers
    // ---------------------------------------------------------------
    // Open-drain drives only low; push-pull drives both levels.
    always @(posedge clock) begin
        if (rst) begin
            pinOut <= 8'h00;
            pinOutEn <= 8'h00;
            pinPullUpEn <= 8'h00;
        end else begin
            pinOut <= bidirPins & outValue;
            pinOutEn <= bidirPins & outEnBits & (pushPullBits | ~outValue);
            pinPullUpEn <= pullUpBits;
        end
    end

    // ---------------------------------------------------------------
    // Sampled pins and pending copy
    // ---------------------------------------------------------------

    always @(posedge clock) begin
        if (rst) begin
            pinSample <= 8'h00;
            eventPending <= 8'h00;
        end else begin
            pinSample <= pinIn;
            eventPending <= eventStatus;
        end
    end

endmodule

// file: standby_gpio_event_port_props.sv
// Checker for the standby GPIO event port, bound to every instance.
// Assumes the register header is on the include path.
`timescale 1ns/1ps
`include "standby_gpio_regs.vh"
module standby_gpio_event_port_props (
    input wire clock,
    input wire rst,
    input wire standbyPowerUpRst,
    input wire controllerActive,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [7:0] pinIn,
    input wire [7:0] pinOut,
    input wire [7:0] pinOutEn
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire rtAddr = paddr == `ADDR_OUT_VALUE || paddr == `ADDR_IN_LEVEL;
    wire mapped = rtAddr || paddr == `ADDR_PIN_INDEX || paddr == `ADDR_PIN_CONFIG || paddr == `ADDR_EVENT_STATUS;
    wire done = psel && penable && pready;
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        pready ##1 !pready;
    endsequence
    chk_answer_once: assert property (setup_s |=> answer_s)
        else $error("setup not answered in one cycle");
    chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_unmapped_error: assert property (done && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_inactive_refused: assert property (done && rtAddr && !controllerActive |-> pslverr)
        else $error("runtime access not blocked");
    chk_outputs_held: assert property (!controllerActive && !(psel && pwrite)
        |=> $stable(pinOut) && $stable(pinOutEn))
        else $error("pins moved while inactive");
    chk_input_only: assert property (pinOutEn[7:6] == 2'b00 && pinOut[7:6] == 2'b00)
        else $error("input-only pin driven");
    chk_level_readback: assert property (done && !pwrite && paddr == `ADDR_IN_LEVEL && controllerActive
        |-> ((prdata[7:0] ^ pinIn) & ~(pinIn ^ $past(pinIn)) & ~(pinIn ^ $past(pinIn, 2))) == 8'h00)
        else $error("data-in differs from steady pins");
    chk_powerup_quiet: assert property ($fell(standbyPowerUpRst) |-> pinOutEn == 8'h00 && !pready)
        else $error("outputs active after power-up");
endmodule
bind standby_gpio_event_port standby_gpio_event_port_props i_props (.clock(clock), .rst(rst),
    .standbyPowerUpRst(standbyPowerUpRst), .controllerActive(controllerActive), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOutEn(pinOutEn));

// file: standby_gpio_event_port_tb.sv
// Testbench: APB accesses to the standby port, board model on the pins.
// Assumes debounce stays at its full length, so only its holding off is seen.
`timescale 1ns/1ps
`include "standby_gpio_regs.vh"
module standby_gpio_event_port_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic standbyPowerUpRst = 1'b1;
    logic controllerActive = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pinIn;
    logic [7:0] pinOut;
    logic [7:0] pinOutEn;
    logic [7:0] pinPullUpEn;
    logic [7:0] eventPending;
    logic [7:0] extLevel = 8'h00;
    logic [7:0] extEn = 8'h00;
    logic [7:0] rd;
    logic err;
    int err_total = 0;
    int compares = 0;
    standby_gpio_event_port i_dut (.clock(clock), .rst(rst), .standbyPowerUpRst(standbyPowerUpRst),
        .controllerActive(controllerActive), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOutEn(pinOutEn),
        .pinPullUpEn(pinPullUpEn), .eventPending(eventPending));
    pin_board_model i_board (.clock(clock), .pinOut(pinOut), .pinOutEn(pinOutEn),
        .pinPullUpEn(pinPullUpEn), .extLevel(extLevel), .extEn(extEn), .pinLevel(pinIn));
    initial begin
        forever #25 clock = ~clock;
    end
    // --------------------------------------------------------------
    // Bus and comparison tasks
    // --------------------------------------------------------------
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rx(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
        bus(1'b0, a, 8'h00);
        check8(rd & m, e);
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        standbyPowerUpRst <= 1'b0;
        rx(`ADDR_PIN_INDEX, 8'h00, 8'hff);
        rx(`ADDR_PIN_CONFIG, 8'h44, 8'hff);
        rx(`ADDR_OUT_VALUE, 8'h3f, 8'hff);
        bus(1'b1, `ADDR_PIN_INDEX, 8'hff);
        rx(`ADDR_PIN_INDEX, 8'h17, 8'hff);
        bus(1'b1, `ADDR_PIN_INDEX, 8'h10);
        bus(1'b1, `ADDR_PIN_CONFIG, 8'h01);
        rx(`ADDR_PIN_CONFIG, 8'h00, 8'hff);
        bus(1'b0, 12'h100, 8'h00);
        check8({7'h0, err}, 8'h01);
        bus(1'b1, `ADDR_PIN_INDEX, 8'h00);
        bus(1'b1, `ADDR_PIN_CONFIG, 8'h03);
        bus(1'b1, `ADDR_PIN_INDEX, 8'h01);
        bus(1'b1, `ADDR_PIN_CONFIG, 8'h01);
        settle(2);
        check8(pinOutEn, 8'h01);
        check8(pinPullUpEn, 8'h3c);
        bus(1'b1, `ADDR_OUT_VALUE, 8'h00);
        settle(2);
        check8(pinOutEn, 8'h03);
        check8(pinOut & 8'h03, 8'h00);
        rx(`ADDR_IN_LEVEL, 8'h00, 8'h03);
        bus(1'b1, `ADDR_OUT_VALUE, 8'h01);
        bus(1'b1, `ADDR_IN_LEVEL, 8'h00);
        check8({7'h0, err}, 8'h00);
        rx(`ADDR_IN_LEVEL, 8'h01, 8'h01);
        rx(`ADDR_OUT_VALUE, 8'h01, 8'hff);
        controllerActive <= 1'b0;
        bus(1'b1, `ADDR_OUT_VALUE, 8'h00);
        rx(`ADDR_OUT_VALUE, 8'h00, 8'hff);
        check8({7'h0, err}, 8'h01);
        settle(2);
        check8(pinOut & pinOutEn, 8'h01);
        @(posedge clock);
        controllerActive <= 1'b1;
        rx(`ADDR_OUT_VALUE, 8'h01, 8'hff);
        bus(1'b1, `ADDR_PIN_INDEX, 8'h02);
        bus(1'b1, `ADDR_PIN_CONFIG, 8'h0b);
        bus(1'b1, `ADDR_PIN_CONFIG, 8'h30);
        rx(`ADDR_PIN_CONFIG, 8'h3b, 8'hff);
        bus(1'b1, `ADDR_OUT_VALUE, 8'h05);
        rx(`ADDR_OUT_VALUE, 8'h01, 8'hff);
        // Software reset keeps the lock; only the standby power-up reset clears it
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        bus(1'b1, `ADDR_PIN_INDEX, 8'h02);
        rx(`ADDR_PIN_CONFIG, 8'h4b, 8'hff);
        rx(`ADDR_OUT_VALUE, 8'h3b, 8'hff);
        @(posedge clock);
        rst <= 1'b1;
        standbyPowerUpRst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        standbyPowerUpRst <= 1'b0;
        bus(1'b1, `ADDR_PIN_INDEX, 8'h02);
        rx(`ADDR_PIN_CONFIG, 8'h44, 8'hff);
        extEn <= 8'h18;
        bus(1'b1, `ADDR_PIN_INDEX, 8'h03);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, `ADDR_PIN_CONFIG, {2'b00, k[1], k[0], 4'h0});
            extLevel[3] <= ~k[1];
            settle(5);
            bus(1'b1, `ADDR_EVENT_STATUS, 8'h08);
            settle(5);
            check8(eventPending & 8'h08, 8'h00);
            @(posedge clock);
            extLevel[3] <= k[1];
            settle(5);
            check8(eventPending & 8'h08, 8'h08);
        end
        check8(eventPending & 8'h10, 8'h00);
        report_and_stop();
    end
endmodule

// file: standby_gpio_regs.vh
// Register offsets, field positions, reset values and timing counts
// for the standby GPIO event port. Included by the port module, its checker and the testbench.
`ifndef STANDBY_GPIO_REGS_VH
`define STANDBY_GPIO_REGS_VH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define IDX_PIN_INDEX 8'h13
`define IDX_PIN_CONFIG 8'h14
`define IDX_OUT_VALUE 8'h08
`define IDX_IN_LEVEL 8'h09
`define IDX_EVENT_STATUS 8'h0a
`define ADDR_PIN_INDEX 12'h04c
`define ADDR_PIN_CONFIG 12'h050
`define ADDR_OUT_VALUE 12'h020
`define ADDR_IN_LEVEL 12'h024
`define ADDR_EVENT_STATUS 12'h028

// ---------------------------------------------------------------
// Configuration fields
// ---------------------------------------------------------------
`define CFG_OUT_EN 0
`define CFG_PUSH_PULL 1
`define CFG_PULL_UP 2
`define CFG_LOCK 3
`define CFG_LEVEL_TYPE 4
`define CFG_POLARITY 5
`define CFG_DEBOUNCE 6
`define CFG_RESET 8'h44
`define CFG_WRITE_MASK 8'h7f
`define CFG_INPUT_ONLY_MASK 8'h70
`define SEL_WRITE_MASK 8'h17
`define SEL_RESET 8'h00
`define OUT_RESET 8'h3f
`define BIDIR_MASK 8'h3f

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLOCK_HZ 20000000
`define DEBOUNCE_MS 15
`define DEBOUNCE_TICK_CYCLES (`CLOCK_HZ / 1000)

`endif
